//--- shared/sps_pkg.sv
// shared constants and carriers of the protection sequencer
package sps_pkg;

  localparam int CLK_HZ = 40_000_000;
  // overload blanking, milliseconds
  localparam int OVERLOAD_BLANK_MS = 30;
  localparam int OVERLOAD_BLANK_CYC = (CLK_HZ / 1000) * OVERLOAD_BLANK_MS;
  // maximum gate-high time, microseconds
  localparam int MAX_GATE_HIGH_US = 30;
  localparam int MAX_GATE_HIGH_CYC = (CLK_HZ / 1_000_000) * MAX_GATE_HIGH_US;
  // output over-voltage blanking, nanoseconds
  localparam int OUT_OV_BLANK_NS = 1000;
  localparam int OUT_OV_BLANK_CYC =
    (OUT_OV_BLANK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  localparam logic [3:0] VALLEY_RELOAD = 4'h1;
  localparam logic [6:0] LIMIT_BURST_PCT = 7'h22;
  localparam logic [6:0] LIMIT_FULL_PCT = 7'h64;

  typedef enum logic [2:0] {
    SPS_OFF = 3'b000,
    SPS_RUN = 3'b001,
    SPS_BURST = 3'b010,
    SPS_RESTART = 3'b011,
    SPS_LATCHED = 3'b100
  } sps_state_e;

  // analog comparator indications
  typedef struct packed {
    logic supply_uv;
    logic supply_ov;
    logic below_turnoff;
    logic above_turnon;
    logic below_powerdown;
    logic fb_above_exit;
    logic fb_below_pause;
    logic fb_above_resume;
    logic fb_pulled_high;
    logic out_ov;
    logic overtemp;
    logic short_winding;
  } sps_sense_s;

endpackage

//--- tb/sps_stage.sv
// flyback power stage and sense network model
`timescale 1ns/1ps
`default_nettype none
module sps_stage (
  // gate from the controller
  input wire logic gate_on,
  // conditions set by the bench
  input wire sps_pkg::sps_sense_s cond,
  // comparator levels
  output var sps_pkg::sps_sense_s sense_pin
);
  // winding current seen only while on, ringing only while off
  always_comb
  begin
    sense_pin = cond;
    sense_pin.short_winding = cond.short_winding & gate_on;
    sense_pin.out_ov = cond.out_ov & ~gate_on;
  end
endmodule
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench of the protection sequencer
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int OLB = 50;
  localparam int MGH = 20;
  localparam int OVB = 4;
  logic sys_clk;
  logic rst;
  sps_pkg::sps_sense_s cond;
  sps_pkg::sps_sense_s sense;
  logic burst_req;
  logic gate_req;
  logic gate_on;
  logic charge_en;
  logic ss_pulse;
  logic burst_mode;
  logic burst_sw;
  logic latched;
  logic restart;
  logic [6:0] limit;
  logic vload;
  logic [3:0] vval;
  int err_total;
  int samples_checked;
  int n;
  int sel[3] = '{11, 10, 1};

  sps_sequencer #(.OVERLOAD_BLANK_CYC(OLB), .MAX_GATE_HIGH_CYC(MGH),
    .OUT_OV_BLANK_CYC(OVB)) u_dut (.sys_clk(sys_clk), .rst(rst),
    .sense_pin(sense), .burst_enter_req(burst_req), .gate_req(gate_req),
    .gate_on(gate_on), .startup_charge_en(charge_en),
    .soft_start_pulse(ss_pulse), .burst_mode(burst_mode),
    .burst_switching(burst_sw), .latched_off(latched),
    .auto_restart(restart), .current_limit_pct(limit),
    .valley_load(vload), .valley_load_value(vval));
  sps_stage u_stage (.gate_on(gate_on), .cond(cond), .sense_pin(sense));

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return ss_pulse;
      1: return vload;
      2: return restart;
      3: return latched;
      default: return burst_mode;
    endcase
  endfunction

  // bounded wait for one output to go high
  task automatic wait_hi(input int s, input int lim);
    n = 0;
    while (pick(s) !== 1'b1 && n < lim)
    begin
      cyc(1);
      n++;
    end
    check(8'(n < lim), 8'h01);
  endtask

  task automatic power_up();
    cond.above_turnon = 1'b1;
    wait_hi(0, 8);
    cond.above_turnon = 1'b0;
    cyc(4);
  endtask

  task automatic recover();
    gate_req = 1'b1;
    cyc(3);
    check(8'(gate_on), 8'h00);
    gate_req = 1'b0;
    cond.below_turnoff = 1'b1;
    cyc(5);
    check(8'(charge_en), 8'h01);
    cond.below_turnoff = 1'b0;
    power_up();
  endtask

  task automatic unlatch();
    cond = '0;
    gate_req = 1'b0;
    cond.below_powerdown = 1'b1;
    cyc(5);
    check(8'(latched), 8'h00);
    cond.below_powerdown = 1'b0;
    power_up();
  endtask

  initial
  begin
    #200_000;
    err_total++;
    end_sim();
  end

  // ---------------------------------------------
  // tests
  // ---------------------------------------------
  initial
  begin
    err_total = 0;
    samples_checked = 0;
    rst = 1'b1;
    cond = '0;
    burst_req = 1'b0;
    gate_req = 1'b0;
    cyc(10);
    rst = 1'b0;
    check(8'(gate_on), 8'h00);
    check(8'(charge_en), 8'h01);
    check(8'(limit), 8'h64);
    cyc(2);
    power_up();
    burst_req = 1'b1;
    wait_hi(4, 8);
    burst_req = 1'b0;
    check(8'(limit), 8'h22);
    check(8'(burst_sw), 8'h00);
    cond.fb_above_resume = 1'b1;
    cyc(5);
    check(8'(burst_sw), 8'h01);
    gate_req = 1'b1;
    cond.overtemp = 1'b1;
    cond.fb_pulled_high = 1'b1;
    cond.short_winding = 1'b1;
    cyc(OLB + 20);
    check(8'(restart), 8'h00);
    check(8'(latched), 8'h00);
    cond = '0;
    gate_req = 1'b0;
    cond.fb_below_pause = 1'b1;
    cyc(5);
    check(8'(burst_sw), 8'h00);
    cond.fb_below_pause = 1'b0;
    cond.fb_above_exit = 1'b1;
    wait_hi(1, 8);
    check(8'(vval), 8'h01);
    check(8'(burst_mode), 8'h00);
    check(8'(limit), 8'h64);
    cyc(1);
    check(8'(vload), 8'h00);
    cond.fb_above_exit = 1'b0;
    gate_req = 1'b1;
    cyc(1);
    n = 1;
    while (gate_on === 1'b1 && n < 100)
    begin
      cyc(1);
      n++;
    end
    check(8'(n >= MGH && n <= MGH + 1), 8'h01);
    gate_req = 1'b0;
    cyc(3);
    check(8'(gate_on), 8'h00);
    cond.fb_pulled_high = 1'b1;
    cyc(OLB - 10);
    cond.fb_pulled_high = 1'b0;
    cyc(4);
    check(8'(restart), 8'h00);
    cond.fb_pulled_high = 1'b1;
    cyc(OLB - 5);
    check(8'(restart), 8'h00);
    wait_hi(2, 15);
    cond.fb_pulled_high = 1'b0;
    recover();
    foreach (sel[i])
    begin
      cond[sel[i]] = 1'b1;
      wait_hi(2, 8);
      cond[sel[i]] = 1'b0;
      recover();
    end
    cond.out_ov = 1'b1;
    cyc(2);
    cond.out_ov = 1'b0;
    cyc(5);
    check(8'(latched), 8'h00);
    cond.out_ov = 1'b1;
    wait_hi(3, 12);
    cond.out_ov = 1'b0;
    cond.below_turnoff = 1'b1;
    gate_req = 1'b1;
    cyc(5);
    check(8'(charge_en), 8'h01);
    check(8'(gate_on), 8'h00);
    cond.below_turnoff = 1'b0;
    cond.above_turnon = 1'b1;
    cyc(5);
    check(8'(charge_en), 8'h00);
    check(8'(latched), 8'h01);
    unlatch();
    gate_req = 1'b1;
    cyc(1);
    cond.short_winding = 1'b1;
    cond.overtemp = 1'b1;
    wait_hi(3, 12);
    cyc(MGH);
    check(8'(restart), 8'h00);
    check(8'(gate_on), 8'h00);
    unlatch();
    end_sim();
  end
endmodule
`default_nettype wire

//--- verilog/sps_sequencer.sv
// burst exit and protection sequencer of a flyback controller
// Behaviour
// - in burst, leave burst as soon as feedback exceeds the exit level.
// - burst uses a 34 percent current limit, full limit restored on exit.
// - on leaving burst the valley counter is loaded with 1.
// - supply under- or over-voltage resets state and holds the gate off.
// - after a supply fault, charge below turn-off, resume with soft-start at turn-on.
// - feedback held high enters auto-restart only after 30 ms continuous.
// - overload detection and its timer are inhibited in burst.
// - output over-voltage held for its blanking time in off-time latches off.
// - latch-off clears only when supply falls below the power-down level.
// - over-temperature enters auto-restart, ignored in burst.
// - short-winding sense during on-time latches off, inhibited in burst.
// - latched off, charging cycles between turn-off and turn-on, gate off.
// - gate forced off when high longer than the maximum on-time.
// - supply, overload and thermal faults restart; output OV and short latch.
// - in burst, switching stops at the pause level, resumes above resume.
`timescale 1ns/1ps
`default_nettype none
module sps_sequencer #(
  parameter int OVERLOAD_BLANK_CYC = sps_pkg::OVERLOAD_BLANK_CYC,
  parameter int MAX_GATE_HIGH_CYC = sps_pkg::MAX_GATE_HIGH_CYC,
  parameter int OUT_OV_BLANK_CYC = sps_pkg::OUT_OV_BLANK_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // comparator pins
  input wire sps_pkg::sps_sense_s sense_pin,
  // modulator requests
  input wire logic burst_enter_req,
  input wire logic gate_req,
  // gate and supply control
  output logic gate_on,
  output logic startup_charge_en,
  output logic soft_start_pulse,
  // mode and limit
  output logic burst_mode,
  output logic burst_switching,
  output logic latched_off,
  output logic auto_restart,
  output logic [6:0] current_limit_pct,
  output logic valley_load,
  output logic [3:0] valley_load_value
);

  localparam int CW = 24;

  // elaboration check of the counter limits
  if (OVERLOAD_BLANK_CYC < 1 || OVERLOAD_BLANK_CYC >= (1 << CW) ||
      MAX_GATE_HIGH_CYC < 1 || MAX_GATE_HIGH_CYC >= (1 << CW) ||
      OUT_OV_BLANK_CYC < 1 || OUT_OV_BLANK_CYC >= (1 << CW))
  begin
    $error("sps_sequencer count parameter out of range");
  end

  function automatic logic [CW-1:0] cnt_step(input logic run,
                                             input logic [CW-1:0] c,
                                             input int lim);
    if (!run)
      cnt_step = '0;
    else if (c < CW'(lim))
      cnt_step = c + CW'(1);
    else
      cnt_step = c;
  endfunction

  // ----------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------
  sps_pkg::sps_sense_s s;
  logic [$bits(sps_pkg::sps_sense_s)-1:0] s_bits;

  sps_sync #(.WIDTH($bits(sps_pkg::sps_sense_s))) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .async_in(sense_pin),
    .sync_out(s_bits)
  );
  assign s = sps_pkg::sps_sense_s'(s_bits);

  // ----------------------------------------------------------------
  // state machine and timers
  // ----------------------------------------------------------------
  sps_pkg::sps_state_e st_q, st_d;
  logic [CW-1:0] ol_q, ol_d, ov_q, ov_d, on_q, on_d;
  logic gate_q, gate_d, chg_q, chg_d, ss_q, ss_d, sw_q, sw_d;
  logic vl_q, vl_d;
  logic [6:0] lim_q, lim_d;
  logic bm_q, bm_d, lo_q, lo_d, ar_q, ar_d;
  logic [3:0] vv_q, vv_d;
  logic ol_trip, ov_trip, latch_cond, restart_cond, in_burst;

  always_comb
  begin
    in_burst = (st_q == sps_pkg::SPS_BURST);
    // overload timer cleared whenever in burst
    ol_d = cnt_step(s.fb_pulled_high && st_q == sps_pkg::SPS_RUN,
                    ol_q, OVERLOAD_BLANK_CYC);
    ol_trip = (ol_q >= CW'(OVERLOAD_BLANK_CYC));
    ov_d = cnt_step(s.out_ov && !gate_q && (st_q == sps_pkg::SPS_RUN ||
                    in_burst), ov_q, OUT_OV_BLANK_CYC);
    ov_trip = (ov_q >= CW'(OUT_OV_BLANK_CYC));
    latch_cond = ov_trip ||
                 (s.short_winding && gate_q && !in_burst);
    restart_cond = s.supply_uv || s.supply_ov || ol_trip ||
                   (s.overtemp && !in_burst);
    st_d = st_q;
    chg_d = chg_q;
    ss_d = 1'b0;
    vl_d = 1'b0;
    sw_d = sw_q;
    case (st_q)
      sps_pkg::SPS_OFF:
      begin
        chg_d = 1'b1;
        if (s.above_turnon && !s.supply_uv && !s.supply_ov)
        begin
          st_d = sps_pkg::SPS_RUN;
          chg_d = 1'b0;
          ss_d = 1'b1;
        end
      end
      sps_pkg::SPS_RUN, sps_pkg::SPS_BURST:
      begin
        if (latch_cond)
        begin
          st_d = sps_pkg::SPS_LATCHED;
          chg_d = 1'b0;
        end
        else if (restart_cond)
        begin
          st_d = sps_pkg::SPS_RESTART;
          chg_d = 1'b0;
        end
        else if (in_burst && s.fb_above_exit)
        begin
          st_d = sps_pkg::SPS_RUN;
          vl_d = 1'b1;
        end
        else if (!in_burst && burst_enter_req)
        begin
          st_d = sps_pkg::SPS_BURST;
          sw_d = 1'b0;
        end
        else if (in_burst)
        begin
          if (s.fb_below_pause)
            sw_d = 1'b0;
          else if (s.fb_above_resume)
            sw_d = 1'b1;
        end
      end
      sps_pkg::SPS_RESTART:
      begin
        if (s.below_turnoff)
        begin
          st_d = sps_pkg::SPS_OFF;
          chg_d = 1'b1;
        end
      end
      sps_pkg::SPS_LATCHED:
      begin
        if (s.below_powerdown)
        begin
          st_d = sps_pkg::SPS_OFF;
          chg_d = 1'b1;
        end
        else if (s.below_turnoff)
          chg_d = 1'b1;
        else if (s.above_turnon)
          chg_d = 1'b0;
      end
      default:
      begin
        st_d = sps_pkg::SPS_OFF;
        chg_d = 1'b1;
      end
    endcase
    on_d = cnt_step(gate_q, on_q, MAX_GATE_HIGH_CYC);
    gate_d = gate_req &&
             (st_d == sps_pkg::SPS_RUN ||
              (st_d == sps_pkg::SPS_BURST && sw_d)) &&
             !(gate_q && on_q >= CW'(MAX_GATE_HIGH_CYC - 1));
    // mode outputs registered from the next state
    lim_d = (st_d == sps_pkg::SPS_BURST) ? sps_pkg::LIMIT_BURST_PCT :
            sps_pkg::LIMIT_FULL_PCT;
    bm_d = (st_d == sps_pkg::SPS_BURST);
    lo_d = (st_d == sps_pkg::SPS_LATCHED);
    ar_d = (st_d == sps_pkg::SPS_RESTART);
    vv_d = sps_pkg::VALLEY_RELOAD;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      st_q <= sps_pkg::SPS_OFF;
      ol_q <= '0;
      ov_q <= '0;
      on_q <= '0;
      gate_q <= 1'b0;
      chg_q <= 1'b1;
      ss_q <= 1'b0;
      sw_q <= 1'b0;
      vl_q <= 1'b0;
      lim_q <= sps_pkg::LIMIT_FULL_PCT;
      bm_q <= 1'b0;
      lo_q <= 1'b0;
      ar_q <= 1'b0;
      vv_q <= sps_pkg::VALLEY_RELOAD;
    end
    else
    begin
      st_q <= st_d;
      ol_q <= ol_d;
      ov_q <= ov_d;
      on_q <= on_d;
      gate_q <= gate_d;
      chg_q <= chg_d;
      ss_q <= ss_d;
      sw_q <= sw_d;
      vl_q <= vl_d;
      lim_q <= lim_d;
      bm_q <= bm_d;
      lo_q <= lo_d;
      ar_q <= ar_d;
      vv_q <= vv_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign gate_on = gate_q;
  assign startup_charge_en = chg_q;
  assign soft_start_pulse = ss_q;
  assign burst_mode = bm_q;
  assign burst_switching = sw_q;
  assign latched_off = lo_q;
  assign auto_restart = ar_q;
  assign current_limit_pct = lim_q;
  assign valley_load = vl_q;
  assign valley_load_value = vv_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_exit_reload: assert property (@(posedge sys_clk) disable iff (rst)
    (st_q == sps_pkg::SPS_BURST && st_d == sps_pkg::SPS_RUN) |=> valley_load)
    else $error("no valley reload on burst exit");
  a_burst_limit: assert property (@(posedge sys_clk) disable iff (rst)
    burst_mode |-> current_limit_pct == sps_pkg::LIMIT_BURST_PCT)
    else $error("burst limit wrong");
  a_full_limit: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(burst_mode) |-> current_limit_pct == sps_pkg::LIMIT_FULL_PCT)
    else $error("full limit not restored");
  a_latch_gate: assert property (@(posedge sys_clk) disable iff (rst)
    latched_off |-> !gate_on)
    else $error("gate on while latched");
  a_latch_hold: assert property (@(posedge sys_clk) disable iff (rst)
    (latched_off && !s.below_powerdown) |=> latched_off)
    else $error("latch released early");
  a_ontime_max: assert property (@(posedge sys_clk) disable iff (rst)
    gate_on |-> on_q < CW'(MAX_GATE_HIGH_CYC))
    else $error("gate high too long");
  a_olp_burst: assert property (@(posedge sys_clk) disable iff (rst)
    burst_mode |=> ol_q == '0)
    else $error("overload timer ran in burst");
  a_restart_gate: assert property (@(posedge sys_clk) disable iff (rst)
    auto_restart |-> !gate_on)
    else $error("gate on in restart");
  a_supply_fault: assert property (@(posedge sys_clk) disable iff (rst)
    (s.supply_uv && st_q == sps_pkg::SPS_RUN && !latch_cond) |=> auto_restart)
    else $error("supply fault not handled");

endmodule
`default_nettype wire

//--- verilog/sps_sync.sv
// two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
`default_nettype none
module sps_sync #(
  parameter int WIDTH = 12
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // elaboration check of the bundle width
  if (WIDTH < 1)
  begin
    $error("sps_sync width must be positive");
  end

  always_comb
  begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;

endmodule
`default_nettype wire
